// ---- sim/data_mem_model.sv ----
// Behavioural data memory that answers the decoder's read and write pulses
`timescale 1ns/1ps
`default_nettype none

module data_mem_model (
  input wire logic sys_clk,
  input wire xstack_pkg::mem_acc_t rd_req,
  input wire xstack_pkg::mem_acc_t wr_req,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:16383];
  logic [7:0] last_q;

  // =====================================
  // Storage
  // A known pattern lets the bench work out every source byte
  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = i[7:0] ^ 8'h5A;
    last_q = 8'h00;
  end

  // An unselected bus shows the inverse of the last byte, so a stale value never matches
  assign rd_data = rd_req.en ? mem[rd_req.addr] : ~last_q;

  // Writes land at the edge that ends the pulse
  always @(posedge sys_clk)
  begin
    if (rd_req.en)
      last_q <= mem[rd_req.addr];
    if (wr_req.en)
      mem[wr_req.addr] <= wr_req.data;
  end
endmodule
`default_nettype wire

// ---- sim/extended_stack_instr_exec_bench.sv ----
// Self-checking bench for the extended stack instruction decoder
`timescale 1ns/1ps
`default_nettype none

module extended_stack_instr_exec_bench;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic ext_en = 1'h0;
  logic fetch_valid = 1'h0;
  logic [15:0] fetch_word = 16'h0000;
  logic [7:0] rd_data;
  logic fp_wr_en = 1'h0;
  logic [13:0] fp_wr_data = 14'h0000;
  xstack_pkg::mem_acc_t rd_q;
  xstack_pkg::mem_acc_t wr_q;
  logic [13:0] frame_pointer_q;
  logic ext_hit_q, pc_from_stack_q, nop_slot_q;
  int bad_count = 0;
  int tests_run = 0;
  int wr_n = 0, rd_n = 0, hit_n = 0, pc_n = 0, both_n = 0;
  int d_wr, d_rd, d_hit, d_pc, d_both;
  logic [22:0] last_wr, last_rd;

  // =====================================
  // Clock, design and memory
  always #4 sys_clk = ~sys_clk;

  extended_stack_instr_exec u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .instr_extension_enable(ext_en),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .rd_data(rd_data),
    .fp_wr_en(fp_wr_en), .fp_wr_data(fp_wr_data), .rd_q(rd_q), .wr_q(wr_q),
    .frame_pointer_q(frame_pointer_q), .ext_hit_q(ext_hit_q),
    .pc_from_stack_q(pc_from_stack_q), .nop_slot_q(nop_slot_q)
  );

  data_mem_model u_mem (.sys_clk(sys_clk), .rd_req(rd_q), .wr_req(wr_q), .rd_data(rd_data));

  // Pulses are counted, so a doubled or missing pulse shows as a wrong count
  always @(posedge sys_clk)
  begin
    if (wr_q.en === 1'h1)
    begin
      wr_n++;
      last_wr = wr_q;
    end
    if (rd_q.en === 1'h1)
    begin
      rd_n++;
      last_rd = rd_q;
    end
    if (ext_hit_q === 1'h1) hit_n++;
    if (pc_from_stack_q === 1'h1) pc_n++;
    if ((pc_from_stack_q & nop_slot_q) === 1'h1) both_n++;
  end

  // =====================================
  // Shared tasks
  task automatic check(input string what, input logic [22:0] exp, input logic [22:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic load_fp(input logic [13:0] v);
    @(posedge sys_clk);
    fp_wr_en <= 1'h1;
    fp_wr_data <= v;
    @(posedge sys_clk);
    fp_wr_en <= 1'h0;
  endtask

  // Words go out back to back; the idle tail lets every pulse be counted
  task automatic run(input logic [15:0] w0, w1, w2, input int n);
    logic [15:0] w [3];
    int s_wr, s_rd, s_hit, s_pc, s_both;
    w = '{w0, w1, w2};
    {s_wr, s_rd, s_hit, s_pc, s_both} = {wr_n, rd_n, hit_n, pc_n, both_n};
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      fetch_valid <= 1'h1;
      fetch_word <= w[i];
    end
    @(posedge sys_clk);
    fetch_valid <= 1'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    {d_wr, d_rd, d_hit, d_pc, d_both} = {wr_n - s_wr, rd_n - s_rd, hit_n - s_hit, pc_n - s_pc, both_n - s_both};
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // =====================================
  // Scenarios
  task automatic t_disabled;
    run(16'hEA08, 16'h0000, 16'h0000, 1);
    check("hits off", 23'h0, 23'(d_hit));
    check("writes off", 23'h0, 23'(d_wr));
    $display("test disabled done");
  endtask

  task automatic t_push;
    load_fp(14'h01EC);
    run(16'hEA08, 16'h0000, 16'h0000, 1);
    check("push write", {1'h1, 14'h01EC, 8'h08}, last_wr);
    check("push fp", 23'h01EB, 23'(frame_pointer_q));
    run(16'hEA11, 16'hEA22, 16'h0000, 2);
    check("push pair writes", 23'h2, 23'(d_wr));
    check("push pair last", {1'h1, 14'h01EA, 8'h22}, last_wr);
    load_fp(14'h0000);
    run(16'hEAFF, 16'h0000, 16'h0000, 1);
    check("push wrap fp", 23'h3FFF, 23'(frame_pointer_q));
    $display("test push done");
  endtask

  task automatic t_ret(input logic [15:0] w, input logic [13:0] exp_fp);
    load_fp(14'h03FF);
    run(w, 16'h0000, 16'h0000, 1);
    check("return fp", 23'(exp_fp), 23'(frame_pointer_q));
    check("return pc", 23'h1, 23'(d_pc));
    check("return bubble", 23'h1, 23'(d_both));
    check("return hit", 23'h1, 23'(d_hit));
    $display("test return %h done", w);
  endtask

  task automatic t_short;
    load_fp(14'h3F00);
    run(16'hEB05, 16'hF123, 16'h0000, 2);
    check("short read", {1'h1, 14'h0F05, 8'h00}, last_rd);
    check("short write", {1'h1, 14'h0123, 8'h5F}, last_wr);
    $display("test short done");
  endtask

  task automatic t_pair(input logic [6:0] zs, zd, input int n_wr, input logic [22:0] exp_wr);
    load_fp(14'h0FD0);
    run({9'h1D7, zs}, {9'h1E0, zd}, 16'h0000, 2);
    check("pair write count", 23'(n_wr), 23'(d_wr));
    if (n_wr == 1) check("pair write", exp_wr, last_wr);
    $display("test pair %h %h done", zs, zd);
  endtask

  task automatic t_long;
    load_fp(14'h1000);
    run(16'h0062, 16'hF1FF, 16'hFABC, 3);
    check("long read", {1'h1, 14'h107F, 8'h00}, last_rd);
    check("long write", {1'h1, 14'h3ABC, 8'h25}, last_wr);
    check("long hit", 23'h1, 23'(d_hit));
    load_fp(14'h0FD0);
    run(16'h0062, 16'hF040, 16'hF123, 3);
    check("long indirect source", {1'h1, 14'h0123, 8'h00}, last_wr);
    run(16'h0062, 16'hF000, 16'hFFF9, 3);
    check("long guarded writes", 23'h0, 23'(d_wr));
    $display("test long done");
  endtask

  task automatic t_stray;
    run(16'hF123, 16'h0000, 16'h0000, 1);
    check("stray activity", 23'h0, 23'(d_wr + d_rd + d_hit + d_pc));
    $display("test stray done");
  endtask

  // =====================================
  // Main sequence and watchdog
  initial
  begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    t_disabled();
    @(posedge sys_clk);
    ext_en <= 1'h1;
    repeat (4) @(posedge sys_clk);
    t_push();
    t_ret(16'hE8FF, 14'h043E);
    t_ret(16'hE9FF, 14'h03C0);
    t_short();
    t_pair(7'h10, 7'h02, 1, {1'h1, 14'h0FD2, 8'h00});
    t_pair(7'h01, 7'h15, 0, 23'h0);
    t_pair(7'h01, 7'h29, 0, 23'h0);
    t_pair(7'h03, 7'h04, 1, {1'h1, 14'h0FD4, 8'h89});
    t_long();
    t_stray();
    results();
  end

  // The tests need well under a thousand cycles
  initial
  begin
    #40000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire

// ---- src/extended_stack_instr_exec.sv ----
// Decode and execution of the frame-pointer based extended instructions
`timescale 1ns/1ps
`default_nettype none
`include "xstack_map.svh"

module extended_stack_instr_exec (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic instr_extension_enable,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic [7:0] rd_data,
  input wire logic fp_wr_en,
  input wire logic [13:0] fp_wr_data,
  output xstack_pkg::mem_acc_t rd_q,
  output xstack_pkg::mem_acc_t wr_q,
  output logic [13:0] frame_pointer_q,
  output logic ext_hit_q,
  output logic pc_from_stack_q,
  output logic nop_slot_q
);

  // ==========================================================
  // Helper functions
  // Frame-relative address; the sum wraps within the pointer width
  function automatic logic [13:0] idx_addr(input logic [13:0] base, input logic [6:0] off, input logic short_form);
    logic [13:0] sum;
    sum = base + {7'h00, off};
    idx_addr = short_form ? {2'b00, sum[11:0]} : sum;
  endfunction

  function automatic logic is_indirect(input logic [13:0] a);
    is_indirect = (a >= `IND_LO) && (a <= `IND_HI);
  endfunction

  // Writing these would corrupt the return path, so long and pair moves drop such stores; short moves still write them
  function automatic logic is_guarded(input logic [13:0] a);
    is_guarded = (a == `ADDR_PROG_COUNTER_LOW) || (a == `ADDR_STACK_TOP_LOW)
      || (a == `ADDR_STACK_TOP_HIGH) || (a == `ADDR_STACK_TOP_UPPER);
  endfunction

  // ==========================================================
  // Enable synchroniser; the configuration bit is a pin level
  logic en_meta_q;
  logic en_q;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      en_meta_q <= `EXT_EN_RESET;
      en_q <= `EXT_EN_RESET;
    end
    else
    begin
      en_meta_q <= instr_extension_enable;
      en_q <= en_meta_q;
    end
  end

  // ==========================================================
  // First-word decode
  xstack_pkg::exec_state_t state_q;
  xstack_pkg::exec_state_t state_d;
  logic [13:0] dest_q;
  logic src_ind_q;
  logic [7:0] src_hold_q;

  wire in_decode = (state_q == xstack_pkg::ST_DECODE) && fetch_valid && en_q;
  wire [7:0] hi_byte = fetch_word[15:8];
  wire dec_add_ret = in_decode && (fetch_word[15:6] == `OP_ADD_RET);
  wire dec_sub_ret = in_decode && (fetch_word[15:6] == `OP_SUB_RET);
  wire dec_short = in_decode && (hi_byte == `OP_MOVE_GRP) && !fetch_word[7];
  wire dec_pair = in_decode && (hi_byte == `OP_MOVE_GRP) && fetch_word[7];
  wire dec_push = in_decode && (hi_byte == `OP_PUSH);
  wire dec_long = in_decode && (fetch_word == `OP_LONG);
  // A lone tail word matches no pattern above and passes as a no-operation
  wire tail_word = fetch_word[15:12] == `OP_TAIL;
  wire dec_any = dec_add_ret | dec_sub_ret | dec_short | dec_pair | dec_push | dec_long;

  // Source addresses for the reads issued on first and second words
  wire [13:0] short_src = idx_addr(frame_pointer_q, fetch_word[6:0], 1'b1);
  wire [13:0] long_src = idx_addr(frame_pointer_q, fetch_word[8:2], 1'b0);
  wire [13:0] pair_dest = idx_addr(frame_pointer_q, fetch_word[6:0], 1'b1);
  wire [13:0] long_dest = {dest_q[13:12], fetch_word[11:0]};
  wire [7:0] src_byte = rd_q.en ? rd_data : src_hold_q;
  wire [7:0] src_value = src_ind_q ? `ZERO_BYTE : src_byte;

  // Tail words advance the sequence only when they carry the 1111 prefix
  wire tail_ok = fetch_valid && tail_word && en_q;
  wire short_done = (state_q == xstack_pkg::ST_SHORT2) && tail_ok;
  wire long_step2 = (state_q == xstack_pkg::ST_LONG2) && tail_ok;
  wire long_done = (state_q == xstack_pkg::ST_LONG3) && tail_ok;
  wire pair_done = (state_q == xstack_pkg::ST_PAIR2) && tail_ok;
  wire [13:0] short_dest = {2'b00, fetch_word[11:0]};
  wire pair_write = pair_done && !is_indirect(pair_dest) && !is_guarded(pair_dest);
  wire long_write = long_done && !is_guarded(long_dest);
  wire ret_now = dec_add_ret || dec_sub_ret;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      xstack_pkg::ST_DECODE:
      begin
        if (ret_now)
          state_d = xstack_pkg::ST_RET_NOP;
        else if (dec_short)
          state_d = xstack_pkg::ST_SHORT2;
        else if (dec_long)
          state_d = xstack_pkg::ST_LONG2;
        else if (dec_pair)
          state_d = xstack_pkg::ST_PAIR2;
      end
      xstack_pkg::ST_SHORT2:
        if (short_done || !en_q)
          state_d = xstack_pkg::ST_DECODE;
      xstack_pkg::ST_LONG2:
        if (!en_q)
          state_d = xstack_pkg::ST_DECODE;
        else if (long_step2)
          state_d = xstack_pkg::ST_LONG3;
      xstack_pkg::ST_LONG3:
        if (long_done || !en_q)
          state_d = xstack_pkg::ST_DECODE;
      xstack_pkg::ST_PAIR2:
        if (pair_done || !en_q)
          state_d = xstack_pkg::ST_DECODE;
      xstack_pkg::ST_RET_NOP:
        state_d = xstack_pkg::ST_DECODE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= xstack_pkg::ST_DECODE;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // Frame pointer; the core's own load wins over extended updates
  logic [13:0] fp_d;
  always_comb
  begin
    fp_d = frame_pointer_q;
    if (fp_wr_en)
      fp_d = fp_wr_data;
    else if (dec_add_ret)
      fp_d = frame_pointer_q + {8'h00, fetch_word[5:0]};
    else if (dec_sub_ret)
      fp_d = frame_pointer_q - {8'h00, fetch_word[5:0]};
    else if (dec_push)
      fp_d = frame_pointer_q - 14'h0001;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      frame_pointer_q <= `FP_RESET;
    else
      frame_pointer_q <= fp_d;
  end

  // ==========================================================
  // Operand holding between words; read data is kept once it is returned
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dest_q <= 14'h0000;
      src_ind_q <= 1'b0;
      src_hold_q <= 8'h00;
    end
    else
    begin
      if (rd_q.en)
        src_hold_q <= rd_data;
      if (dec_short || dec_pair)
      begin
        src_ind_q <= is_indirect(short_src);
      end
      if (long_step2)
      begin
        src_ind_q <= is_indirect(long_src);
        dest_q <= {fetch_word[1:0], 12'h000};
      end
    end
  end

  // ==========================================================
  // Memory requests: reads at source resolution, writes at completion
  xstack_pkg::mem_acc_t rd_d;
  xstack_pkg::mem_acc_t wr_d;
  always_comb
  begin
    rd_d = '0;
    wr_d = '0;
    if (dec_short || dec_pair)
    begin
      rd_d.en = 1'b1;
      rd_d.addr = short_src;
    end
    else if (long_step2)
    begin
      rd_d.en = 1'b1;
      rd_d.addr = long_src;
    end
    if (dec_push)
    begin
      wr_d.en = 1'b1;
      wr_d.addr = frame_pointer_q;
      wr_d.data = fetch_word[7:0];
    end
    else if (short_done)
    begin
      wr_d.en = 1'b1;
      wr_d.addr = short_dest;
      wr_d.data = src_value;
    end
    else if (long_write)
    begin
      wr_d.en = 1'b1;
      wr_d.addr = long_dest;
      wr_d.data = src_value;
    end
    else if (pair_write)
    begin
      wr_d.en = 1'b1;
      wr_d.addr = pair_dest;
      wr_d.data = src_value;
    end
  end

  // Status strobes toward the core
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_q <= '0;
      wr_q <= '0;
      ext_hit_q <= 1'b0;
      pc_from_stack_q <= 1'b0;
      nop_slot_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      ext_hit_q <= dec_any;
      pc_from_stack_q <= ret_now;
      nop_slot_q <= ret_now;
    end
  end

  // ==========================================================
  // Checks
  sequence push_word_s;
    dec_push;
  endsequence

  sequence short_pair_s;
    dec_short ##1 (state_q == xstack_pkg::ST_SHORT2);
  endsequence

  sequence long_words_s;
    dec_long ##1 long_step2;
  endsequence

  AST_DISABLED_SILENT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !en_q |=> !ext_hit_q && !wr_q.en && !pc_from_stack_q)
    else $error("extended op acted while disabled");

  AST_HIT_NEEDS_EN: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ext_hit_q |-> $past(en_q))
    else $error("hit without enable");

  AST_ADD_RET: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dec_add_ret && !fp_wr_en |=> frame_pointer_q == $past(frame_pointer_q) + {8'h00, $past(fetch_word[5:0])}
    && pc_from_stack_q ##1 !pc_from_stack_q)
    else $error("add-and-return result wrong");

  AST_SUB_RET: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dec_sub_ret && !fp_wr_en |=> frame_pointer_q == $past(frame_pointer_q) - {8'h00, $past(fetch_word[5:0])})
    else $error("subtract-and-return result wrong");

  AST_RET_BUBBLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ret_now |=> state_q == xstack_pkg::ST_RET_NOP && nop_slot_q ##1 state_q == xstack_pkg::ST_DECODE)
    else $error("return bubble missing");

  AST_PUSH: assert property (@(posedge sys_clk) disable iff (!arst_n)
    push_word_s and !fp_wr_en |=> wr_q.en && wr_q.addr == $past(frame_pointer_q)
    && frame_pointer_q == $past(frame_pointer_q) - 14'h0001)
    else $error("push store or decrement wrong");

  AST_SHORT_BANK: assert property (@(posedge sys_clk) disable iff (!arst_n)
    short_pair_s |-> rd_q.en && rd_q.addr[13:12] == 2'b00)
    else $error("short source outside lower 4K");

  AST_IND_SRC_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (short_done || long_write || pair_write) && src_ind_q |=> wr_q.en && wr_q.data == 8'h00)
    else $error("indirect source not read as zero");

  AST_IND_DEST_NOP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pair_done && is_indirect(pair_dest) |=> !wr_q.en)
    else $error("indirect destination written");

  AST_TAIL_IDLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == xstack_pkg::ST_DECODE && fetch_valid && tail_word |=> !ext_hit_q && !wr_q.en)
    else $error("stray tail word executed");

  AST_LONG_THREE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dec_long |=> state_q == xstack_pkg::ST_LONG2)
    else $error("long move sequence broken");

  AST_SUB_RET_PC: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dec_sub_ret |=> pc_from_stack_q && nop_slot_q ##1 !pc_from_stack_q)
    else $error("subtract-and-return did not return");

  AST_RET_FETCH_IGNORED: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == xstack_pkg::ST_RET_NOP |=> !ext_hit_q && !wr_q.en && !rd_q.en)
    else $error("fetch taken during return bubble");

  AST_SHORT_DEST: assert property (@(posedge sys_clk) disable iff (!arst_n)
    short_done |=> wr_q.en && wr_q.addr == {2'b00, $past(fetch_word[11:0])})
    else $error("short move destination wrong");

  AST_LONG_SRC: assert property (@(posedge sys_clk) disable iff (!arst_n)
    long_step2 |=> rd_q.en && rd_q.addr == $past(frame_pointer_q) + {7'h00, $past(fetch_word[8:2])})
    else $error("long move source address wrong");

  AST_LONG_STEPS: assert property (@(posedge sys_clk) disable iff (!arst_n)
    long_words_s |=> state_q == xstack_pkg::ST_LONG3 && rd_q.en)
    else $error("long move did not reach its third word");

  AST_LONG_GUARD: assert property (@(posedge sys_clk) disable iff (!arst_n)
    long_done && is_guarded(long_dest) |=> !wr_q.en)
    else $error("guarded register written by long move");

  AST_PAIR_DEST: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pair_write |=> wr_q.en && wr_q.addr[11:0] == $past(frame_pointer_q[11:0]) + {5'h00, $past(fetch_word[6:0])})
    else $error("pair move destination wrong");

endmodule
`default_nettype wire

// ---- src/xstack_map.svh ----
// Constants for the stack-oriented extended instruction decoder
// What this block does
// - Extension off until config bit set
// - Extended opcodes decode only when enabled
// - Add literal to frame pointer, return, two cycles
// - Add-and-return encoding 1110 1000 11kk kkkk
// - Subtract literal from pointer, return, two cycles
// - Subtract-and-return encoding 1110 1001 11kk kkkk
// - Short move: indexed source to 12-bit destination
// - Short move words 1110 1011 0zzz, 1111 ffff
// - Short forms force top two address bits zero
// - Long move: indexed source, 14-bit destination, three cycles
// - Long move opcode then two 1111 words
// - Long move: indirect source reads zero
// - Indexed-to-indexed move, two words, two cycles
// - Pair move words 1110 1011 1zzz, 1111 xzzz
// - Pair move: indirect source reads zero
// - Pair move to indirect destination writes nothing
// - Push literal at pointer, then decrement, one cycle
// - Push encoding 1110 1010 kkkk kkkk
// - Stray 1111 words execute as no-operation
// - Program counter change adds one no-operation cycle
`ifndef XSTACK_MAP_SVH
`define XSTACK_MAP_SVH
`define AW 14
`define FP_RESET 14'h0000
`define EXT_EN_RESET 1'b0
// Opcode patterns, compared on the high byte, on masked fields or, for OP_LONG, on the whole word
`define OP_ADD_RET 10'h3A3
`define OP_SUB_RET 10'h3A7
`define OP_MOVE_GRP 8'hEB
`define OP_PUSH 8'hEA
`define OP_LONG 16'h0062
`define OP_TAIL 4'hF
// Data addresses of the indirect ports and of the return-path registers
`define IND_LO 14'h0FDB
`define IND_HI 14'h0FEF
`define ADDR_PROG_COUNTER_LOW 14'h0FF9
`define ADDR_STACK_TOP_LOW 14'h0FFD
`define ADDR_STACK_TOP_HIGH 14'h0FFE
`define ADDR_STACK_TOP_UPPER 14'h0FFF
`define ZERO_BYTE 8'h00
`endif

// ---- src/xstack_pkg.sv ----
// Types shared by the extended instruction decoder
package xstack_pkg;
  // One data memory access: enable, byte address and write data
  typedef struct packed {
    logic en;
    logic [13:0] addr;
    logic [7:0] data;
  } mem_acc_t;

  // Execution state of the decoder
  typedef enum logic [2:0] {
    ST_DECODE,
    ST_SHORT2,
    ST_LONG2,
    ST_LONG3,
    ST_PAIR2,
    ST_RET_NOP
  } exec_state_t;
endpackage
